// file: pin_load.sv
`timescale 1ns/100ps
module pin_load #(parameter logic [9:0] ext_pu = 10'h0cc) (
  input wire logic [9:0] oe_n,
  input wire logic [9:0] pu_on,
  output logic [9:0] level
);
  assign level = oe_n & (pu_on | ext_pu);
endmodule : pin_load

// file: seq_out_pkg.sv
package seq_out_pkg;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int unsigned num_outputs = 10;
  localparam int unsigned num_cond = 4;
  localparam int unsigned clock_mhz = 100;
  localparam int unsigned spike_ns = 50;
  localparam int unsigned spike_cycles = (spike_ns * clock_mhz + 999) / 1000;
  localparam int unsigned write_ms = 11;
  localparam int unsigned write_cycles = write_ms * 1000 * clock_mhz * 1000 / 1000;
  localparam int unsigned write_cw = 21;
  localparam logic [3:0] serial_idle = 4'hf;

  // ----------------------------------------
  // Per-output configuration, serial pin group and write states
  // ----------------------------------------
  typedef struct packed {
    logic active_high;
    logic open_drain;
    logic mr_enable;
    logic mr_level;
    logic [3:0] cond_mask;
  } out_cfg_t;

  typedef struct packed {
    logic sda;
    logic scl;
    logic sel0;
    logic sel1;
  } serial_pins_t;

  typedef enum logic [1:0] {
    wr_idle = 2'b00,
    wr_busy = 2'b01,
    wr_extra = 2'b10
  } wr_state_t;

endpackage : seq_out_pkg

// file: seq_out_sva.sv
`timescale 1ns/100ps
module seq_out_sva (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic supply_ok,
  input wire logic hold_input_n,
  input wire logic manual_reset_input_n,
  input wire seq_out_pkg::serial_pins_t serial_in,
  input wire logic write_start,
  input wire logic [9:0] programmable_output_o,
  input wire logic [9:0] programmable_output_oe_n,
  input wire logic [9:0] programmable_output_pullup,
  input wire seq_out_pkg::serial_pins_t serial_filt,
  input wire logic write_busy,
  input wire logic write_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  hold_freeze_a:
    assert property ((!hold_input_n && supply_ok)[*5] |=> $stable(programmable_output_oe_n))
    else $error("outputs moved under hold");
  hold_over_mr_a:
    assert property ((!hold_input_n && !manual_reset_input_n && supply_ok)[*5]
      |=> $stable(programmable_output_oe_n)) else $error("manual reset beat hold");
  lockout_low_a:
    assert property ((!supply_ok)[*3] |=> programmable_output_oe_n == '0)
    else $error("output released under lockout");
  lockout_pu_a:
    assert property ((!supply_ok)[*3] |=> programmable_output_pullup == '0)
    else $error("pullup on under lockout");
  pin_zero_a:
    assert property (programmable_output_o == '0) else $error("pin value not low");
  pu_released_a:
    assert property ((programmable_output_pullup & ~programmable_output_oe_n) == '0)
    else $error("pullup on a driven pin");
  busy_start_a:
    assert property (write_start && !write_busy |=> write_busy) else $error("write not taken");
  busy_min_a:
    assert property ($rose(write_busy) |-> write_busy[*8]) else $error("write ended early");
  done_pulse_a:
    assert property (write_done |=> !write_done && !write_busy) else $error("done not a pulse");
  busy_end_a:
    assert property ($fell(write_busy) |-> write_done || $past(write_done))
    else $error("busy fell without done");
  filt_persist_a:
    assert property ($changed(serial_filt) |-> ((($past(serial_in, 2) ^ serial_filt)
      | ($past(serial_in, 6) ^ serial_filt)) & ($past(serial_filt) ^ serial_filt)) == '0)
    else $error("spike passed filter");
endmodule : seq_out_sva
bind sequencer_output_hold_control seq_out_sva chk_i (.*);

// file: sequencer_output_hold_control.sv
`timescale 1ns/100ps

// Summary of operation
// - Hold input low freezes every programmable output in its present state.
// - Hold wins over manual reset when both are asserted together.
// - Each output selects active-high or active-low, open-drain or weak pullup.
// - Outputs are low until supply clears lockout, then take programmed state.
// - A byte write completes within the maximum write cycle time.
// - First configuration write takes one extra internal write cycle.
// - Serial data, clock and both select inputs reject spikes under 50 ns.
// - Manual reset per output either forces a programmed state or is ignored.
module sequencer_output_hold_control #(
  parameter int unsigned write_cycles = seq_out_pkg::write_cycles
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic supply_ok,
  input wire logic hold_input_n,
  input wire logic manual_reset_input_n,
  input wire logic [seq_out_pkg::num_cond-1:0] cond_in,
  input wire seq_out_pkg::out_cfg_t [seq_out_pkg::num_outputs-1:0] out_cfg,
  input wire seq_out_pkg::serial_pins_t serial_in,
  input wire logic write_start,
  output logic [seq_out_pkg::num_outputs-1:0] programmable_output_o,
  output logic [seq_out_pkg::num_outputs-1:0] programmable_output_oe_n,
  output logic [seq_out_pkg::num_outputs-1:0] programmable_output_pullup,
  output seq_out_pkg::serial_pins_t serial_filt,
  output logic write_busy,
  output logic write_done
);

  // ----------------------------------------
  // Sizes and limits
  // ----------------------------------------
  localparam int unsigned n = seq_out_pkg::num_outputs;
  localparam int unsigned sw = 4;
  localparam logic [3:0] spike_lim = 4'(seq_out_pkg::spike_cycles);
  localparam logic [seq_out_pkg::write_cw-1:0] wr_last =
    seq_out_pkg::write_cw'(write_cycles - 1);

  // ----------------------------------------
  // Registered state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] sup_s;
    logic [1:0] hold_s;
    logic [1:0] mr_s;
    logic [seq_out_pkg::num_cond-1:0] cond_s1;
    logic [seq_out_pkg::num_cond-1:0] cond_s2;
    logic [3:0] ser_s1;
    logic [3:0] ser_s2;
    logic [3:0][3:0] spk_cnt;
    logic [3:0] ser_filt;
    logic [n-1:0] pin_o;
    logic [n-1:0] pin_oe_n;
    logic [n-1:0] pin_pu;
    seq_out_pkg::wr_state_t wr_st;
    logic [seq_out_pkg::write_cw-1:0] wr_cnt;
    logic first_done;
    logic done;
  } state_t;

  state_t s_q;
  state_t s_d;

  always_comb begin
    logic supply_up;
    logic hold;
    logic mr;
    logic want;
    logic level;
    logic differs;
    logic settled;
    supply_up = 1'b0;
    hold = 1'b0;
    mr = 1'b0;
    want = 1'b0;
    level = 1'b0;
    differs = 1'b0;
    settled = 1'b0;
    s_d = s_q;

    // ----------------------------------------
    // Control input synchronisers
    // ----------------------------------------
    s_d.sup_s = {s_q.sup_s[0], supply_ok};
    s_d.hold_s = {s_q.hold_s[0], ~hold_input_n};
    s_d.mr_s = {s_q.mr_s[0], ~manual_reset_input_n};

    // ----------------------------------------
    // Condition and serial synchronisers
    // ----------------------------------------
    s_d.cond_s1 = cond_in;
    s_d.cond_s2 = s_q.cond_s1;
    s_d.ser_s1 = serial_in;
    s_d.ser_s2 = s_q.ser_s1;

    // ----------------------------------------
    // Synchronised levels
    // ----------------------------------------
    supply_up = s_q.sup_s[1];
    hold = s_q.hold_s[1];
    mr = s_q.mr_s[1];

    // ----------------------------------------
    // Spike filter
    // ----------------------------------------
    for (int i = 0; i < sw; i++) begin
      differs = (s_q.ser_s2[i] != s_q.ser_filt[i]);
      settled = (s_q.spk_cnt[i] + 4'h1 >= spike_lim);
      if (!differs) begin
        s_d.spk_cnt[i] = 4'h0;
      end else if (settled) begin
        s_d.ser_filt[i] = s_q.ser_s2[i];
        s_d.spk_cnt[i] = 4'h0;
      end else begin
        s_d.spk_cnt[i] = s_q.spk_cnt[i] + 4'h1;
      end
    end

    for (int i = 0; i < n; i++) begin
      // ----------------------------------------
      // Conditions and manual reset
      // ----------------------------------------
      want = |(s_q.cond_s2 & out_cfg[i].cond_mask);
      if (out_cfg[i].mr_enable && mr) begin
        want = out_cfg[i].mr_level;
      end

      // ----------------------------------------
      // Output polarity
      // ----------------------------------------
      if (want) begin
        level = out_cfg[i].active_high;
      end else begin
        level = ~out_cfg[i].active_high;
      end

      // ----------------------------------------
      // Lockout, hold and drive style
      // ----------------------------------------
      if (!supply_up) begin
        s_d.pin_o[i] = 1'b0;
        s_d.pin_oe_n[i] = 1'b0;
        s_d.pin_pu[i] = 1'b0;
      end else if (hold) begin
        s_d.pin_o[i] = s_q.pin_o[i];
        s_d.pin_oe_n[i] = s_q.pin_oe_n[i];
        s_d.pin_pu[i] = s_q.pin_pu[i];
      end else begin
        s_d.pin_o[i] = 1'b0;
        s_d.pin_oe_n[i] = level;
        if (out_cfg[i].open_drain) begin
          s_d.pin_pu[i] = 1'b0;
        end else begin
          s_d.pin_pu[i] = level;
        end
      end
    end

    // ----------------------------------------
    // Memory write timer
    // ----------------------------------------
    s_d.done = 1'b0;
    unique case (s_q.wr_st)
      seq_out_pkg::wr_idle: begin
        if (write_start) begin
          s_d.wr_cnt = '0;
          if (s_q.first_done) begin
            s_d.wr_st = seq_out_pkg::wr_busy;
          end else begin
            s_d.wr_st = seq_out_pkg::wr_extra;
          end
        end
      end

      seq_out_pkg::wr_extra: begin
        if (s_q.wr_cnt == wr_last) begin
          s_d.wr_cnt = '0;
          s_d.wr_st = seq_out_pkg::wr_busy;
        end else begin
          s_d.wr_cnt = s_q.wr_cnt + 1'b1;
        end
      end

      seq_out_pkg::wr_busy: begin
        if (s_q.wr_cnt == wr_last) begin
          s_d.done = 1'b1;
          s_d.first_done = 1'b1;
          s_d.wr_st = seq_out_pkg::wr_idle;
        end else begin
          s_d.wr_cnt = s_q.wr_cnt + 1'b1;
        end
      end

      default: begin
        s_d.wr_st = seq_out_pkg::wr_idle;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.ser_s1 <= seq_out_pkg::serial_idle;
      s_q.ser_s2 <= seq_out_pkg::serial_idle;
      s_q.ser_filt <= seq_out_pkg::serial_idle;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign programmable_output_o = s_q.pin_o;
  assign programmable_output_oe_n = s_q.pin_oe_n;
  assign programmable_output_pullup = s_q.pin_pu;
  assign serial_filt = s_q.ser_filt;
  assign write_busy = (s_q.wr_st != seq_out_pkg::wr_idle);
  assign write_done = s_q.done;

endmodule : sequencer_output_hold_control

// file: sequencer_output_hold_control_tb_top.sv
`timescale 1ns/100ps
module sequencer_output_hold_control_tb_top;
  logic clock = 0, reset_n = 0, supply_ok = 0, hold_input_n = 1, write_start = 0;
  logic manual_reset_input_n = 1;
  logic [3:0] cond_in = 0;
  seq_out_pkg::serial_pins_t serial_in = 4'hf, serial_filt;
  seq_out_pkg::out_cfg_t [9:0] out_cfg;
  logic [9:0] programmable_output_o, programmable_output_oe_n, programmable_output_pullup, lvl;
  logic write_busy, write_done;
  int miscompares = 0, compares = 0, cyc = 0;
  localparam int write_len = 20;
  sequencer_output_hold_control #(.write_cycles(write_len)) dut (
    .clock(clock),
    .reset_n(reset_n),
    .supply_ok(supply_ok),
    .hold_input_n(hold_input_n),
    .manual_reset_input_n(manual_reset_input_n),
    .cond_in(cond_in),
    .out_cfg(out_cfg),
    .serial_in(serial_in),
    .write_start(write_start),
    .programmable_output_o(programmable_output_o),
    .programmable_output_oe_n(programmable_output_oe_n),
    .programmable_output_pullup(programmable_output_pullup),
    .serial_filt(serial_filt),
    .write_busy(write_busy),
    .write_done(write_done)
  );
  pin_load load_i (.oe_n(programmable_output_oe_n), .pu_on(programmable_output_pullup),
    .level(lvl));
  initial forever #5 clock = ~clock;
  always @(posedge clock) if (++cyc > 1000) begin
    miscompares++;
    tally_and_finish();
  end
  task automatic tk(int n);
    repeat (n) @(negedge clock);
  endtask : tk
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [9:0] want(logic c, logic m);
    for (int i = 0; i < 10; i++) begin
      want[i] = (c | (m & out_cfg[i].mr_enable)) ~^ out_cfg[i].active_high;
    end
  endfunction : want
  task automatic t_lock;
    cond_in = 4'h1;
    tk(6);
    chk("oe_n", 10'h0, programmable_output_oe_n);
    chk("pu", 10'h0, programmable_output_pullup);
    supply_ok = 1;
    tk(4);
    chk("pin", want(1, 0), lvl);
    chk("pin_o", 10'h0, programmable_output_o);
    chk("pu", want(1, 0) & 10'h333, programmable_output_pullup);
    cond_in = 4'h0;
    tk(4);
    chk("pin", want(0, 0), lvl);
    chk("pu", want(0, 0) & 10'h333, programmable_output_pullup);
    manual_reset_input_n = 0;
    tk(4);
    chk("pin", want(0, 1), lvl);
    manual_reset_input_n = 1;
    tk(4);
    chk("pin", want(0, 0), lvl);
    $display("t_lock end");
  endtask : t_lock
  task automatic t_hold;
    hold_input_n = 0;
    tk(4);
    cond_in = 4'h1;
    manual_reset_input_n = 0;
    tk(6);
    chk("pin", want(0, 0), lvl);
    hold_input_n = 1;
    tk(4);
    chk("pin", want(1, 1), lvl);
    manual_reset_input_n = 1;
    $display("t_hold end");
  endtask : t_hold
  task automatic t_write(int e);
    int n = 0;
    write_start = 1;
    tk(1);
    write_start = 0;
    chk("busy", 1, write_busy);
    while (write_done !== 1'b1 && n < 100) begin
      tk(1);
      n++;
    end
    chk("write", e, n);
    chk("busy", 0, write_busy);
    $display("t_write end");
  endtask : t_write
  task automatic t_filt;
    serial_in.sda = 0;
    tk(4);
    serial_in.sda = 1;
    tk(8);
    chk("filt", 4'hf, serial_filt);
    serial_in = 4'h0;
    tk(10);
    chk("filt", 4'h0, serial_filt);
    serial_in = 4'hf;
    tk(10);
    chk("filt", 4'hf, serial_filt);
    $display("t_filt end");
  endtask : t_filt
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    for (int i = 0; i < 10; i++) out_cfg[i] = {i[0], i[1], i[2], 1'b1, 4'h1};
    tk(16);
    reset_n = 1;
    t_write(2 * write_len);
    t_lock();
    t_hold();
    t_write(write_len);
    t_filt();
    tally_and_finish();
  end
endmodule : sequencer_output_hold_control_tb_top
